// File: hdl/iepm_core.sv
// processor core end: vectoring, idle and power-down requests, write gating
`timescale 1ns/1ps
module iepm_core (
    input  wire logic       pclk,
    input  wire logic       presetn,
    iepm_link_if.core       link,
    input  wire logic       idle_cmd,
    input  wire logic       pdown_cmd,
    input  wire logic       reti,
    input  wire logic       ram_wr_req,
    input  wire logic       port_wr_req,
    output logic            ram_wr_en,
    output logic            port_wr_en,
    output logic            vector_valid,
    output logic      [2:0] vector_num,
    output logic            core_active
);
    iepm_pkg::iepm_core_t r;
    iepm_pkg::iepm_core_t next_r;

    // ============================================================
    // next state
    always_comb begin
        next_r           = r;
        next_r.idle_req  = 1'b0;
        next_r.pdown_req = 1'b0;
        next_r.ack       = 6'h00;
        next_r.vvalid    = 1'b0;
        next_r.active    = !link.core_halt && !link.core_reset;
        // writes from the window before reset reach ports, never ram
        next_r.ram_we    = ram_wr_req && next_r.active && !link.ram_write_block;
        next_r.port_we   = port_wr_req && next_r.active;
        if (link.core_reset) begin
            next_r.in_service = 1'b0;
        end else if (next_r.active) begin
            next_r.idle_req  = idle_cmd;
            next_r.pdown_req = pdown_cmd;
            if (reti) begin
                next_r.in_service = 1'b0;
            end else if (!r.in_service && (r.ack == 6'h00) && (|link.irq_pending)
                         && !r.idle_req && !r.pdown_req) begin
                // no vector in the cycle the halt lands
                // lowest set bit wins
                for (int i = 5; i >= 0; i--) begin
                    if (link.irq_pending[i]) begin
                        next_r.vnum = 3'(i);
                    end
                end
                next_r.ack        = 6'h01 << next_r.vnum;
                next_r.vvalid     = 1'b1;
                next_r.in_service = 1'b1;
            end
        end
    end

    // ============================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from the state register
    assign link.idle_req   = r.idle_req;
    assign link.pdown_req  = r.pdown_req;
    assign link.vector_ack = r.ack;
    assign ram_wr_en       = r.ram_we;
    assign port_wr_en      = r.port_we;
    assign vector_valid    = r.vvalid;
    assign vector_num      = r.vnum;
    assign core_active     = r.active;
endmodule

// File: hdl/iepm_ctrl.sv
// interrupt enable, polling and power mode controller with apb registers
// ============================================================
// Overview of operation
// - six sources: two pins, three timers, serial
// - one enable bit per source
// - global bit seven gates every source
// - enable bits at positions zero to five
// - software writes no ones to bit six
// - timer2 request is overflow or external flag
// - timer2 flags cleared only by software
// - timer0/1 flags set STATE5_PHASE2, polled next cycle
// - timer2 flag set STATE2_PHASE2, polled same cycle
// - idle halts core, peripherals keep running
// - idle keeps ram and registers intact
// - enabled pending interrupt or reset ends idle
// - reset from idle: two cycles before reset
// - that window blocks ram writes, not ports
// - no port write right after idle entry
// - power-down stops oscillator after that instruction
// - power-down keeps ram and registers intact
// - only hardware reset ends power-down
// - that reset reloads registers, keeps ram
// - reset held until oscillator is stable
// - falling timer2 pin sets external flag
// - up/down mode external flag toggles, no request
`timescale 1ns/1ps
`include "iepm_defines.svh"
module iepm_ctrl #(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              external_irq_pin_a_n,
    input  wire logic              external_irq_pin_b_n,
    input  wire logic              timer2_external_pin,
    input  wire logic              hw_reset_pin,
    input  wire logic              timer0_overflow,
    input  wire logic              timer1_overflow,
    input  wire logic              timer2_overflow,
    input  wire logic              serial_irq_flag,
    iepm_link_if.dev               link
);
    iepm_pkg::iepm_dev_t r;
    iepm_pkg::iepm_dev_t next_r;

    logic       run;
    logic       state2_phase2;
    logic       s4p1;
    logic       state5_phase2;
    logic       wr;
    logic [2:0] fall;
    logic [5:0] req;

    // ============================================================
    // phase decode and shared terms
    assign run  = (r.mode != iepm_pkg::mode_pdown);  // oscillator stopped in power-down
    assign state2_phase2 = run && (r.phase == `IEPM_PH_STATE2_PHASE2);
    assign s4p1 = run && (r.phase == `IEPM_PH_S4P1);
    assign state5_phase2 = run && (r.phase == `IEPM_PH_STATE5_PHASE2);
    // no register writes while power-down holds state
    assign wr   = psel && penable && r.pready && pwrite && run;
    // falling edge seen between two STATE5_PHASE2 samples
    assign fall = r.smp & ~r.sync_b[2:0];
    // request vector in enable-bit order
    assign req  = {r.t2_ovf | (r.t2_ext & ~r.t2_updown),
                   serial_irq_flag, r.flag};

    // ============================================================
    // next state
    always_comb begin
        next_r         = r;
        next_r.pready  = 1'b0;
        next_r.pslverr = 1'b0;
        // two-stage synchronisers for pins
        next_r.sync_a  = {hw_reset_pin, timer2_external_pin,
                          external_irq_pin_b_n, external_irq_pin_a_n};
        next_r.sync_b  = r.sync_a;

        // machine cycle phase counter, frozen without oscillator
        if (run) begin
            next_r.phase = (r.phase == `IEPM_PHASES) ? 4'h0 : r.phase + 4'h1;
        end

        // core acknowledge clears pin and timer0/1 flags only
        next_r.flag = r.flag & ~{link.vector_ack[3:0]};

        // register writes from software
        if (wr) begin
            if (paddr == `IEPM_OFF_ENABLE) begin
                next_r.ie = pwdata[7:0] & `IEPM_IE_IMPL;
            end else if (paddr == `IEPM_OFF_T2CTL) begin
                next_r.t2_ovf    = pwdata[`IEPM_T2_OVF];  // software clear
                next_r.t2_ext    = pwdata[`IEPM_T2_EXT];
                next_r.t2_ext_en = pwdata[`IEPM_T2_EXT_EN];
            end else if (paddr == `IEPM_OFF_T2MODE) begin
                next_r.t2_updown = pwdata[`IEPM_T2_UPDOWN];
            end
        end

        // overflow pulses wait for their flag-setting phase; set wins over clear
        if (run) begin
            next_r.pend = r.pend | {timer2_overflow, timer1_overflow, timer0_overflow};
        end
        if (state5_phase2) begin
            next_r.smp = r.sync_b[2:0];
            next_r.flag[1] = next_r.flag[1] | next_r.pend[0];  // timer0
            next_r.flag[3] = next_r.flag[3] | next_r.pend[1];  // timer1
            next_r.pend[1:0] = 2'h0;
            next_r.flag[0] = next_r.flag[0] | fall[0];
            next_r.flag[2] = next_r.flag[2] | fall[1];
            if (fall[2] && r.t2_ext_en && !r.t2_updown) begin
                next_r.t2_ext = 1'b1;
            end
        end
        if (state2_phase2 && next_r.pend[2]) begin
            next_r.pend[2] = 1'b0;
            if (r.t2_updown) begin
                next_r.t2_ext = ~next_r.t2_ext;  // seventeenth bit
            end
            next_r.t2_ovf = 1'b1;
        end

        // poll after STATE2_PHASE2 and before STATE5_PHASE2 of each machine cycle
        if (s4p1) begin
            next_r.poll = req;
        end
        next_r.poll = next_r.poll & ~link.vector_ack;
        // pending only with flag, own enable and global enable
        next_r.irq = next_r.poll & next_r.ie[5:0] & {6{next_r.ie[`IEPM_IE_GLOBAL]}};

        // power mode sequencing
        case (r.mode)
            iepm_pkg::mode_run: begin
                if (r.sync_b[3]) begin
                    next_r.mode = iepm_pkg::mode_reset;
                end else if (link.pdown_req) begin
                    next_r.mode = iepm_pkg::mode_pdown;
                end else if (link.idle_req) begin
                    next_r.mode = iepm_pkg::mode_idle;
                end
            end
            iepm_pkg::mode_idle: begin
                next_r.wcnt = 5'h00;
                if (r.sync_b[3]) begin
                    next_r.mode = iepm_pkg::mode_window;
                end else if (|r.irq) begin
                    next_r.mode = iepm_pkg::mode_run;
                end
            end
            iepm_pkg::mode_window: begin
                next_r.wcnt = r.wcnt + 5'h01;
                if (r.wcnt == `IEPM_RST_WIN_CYC) begin
                    next_r.mode = iepm_pkg::mode_reset;
                end
            end
            iepm_pkg::mode_reset: begin
                if (!r.sync_b[3]) begin
                    next_r.mode = iepm_pkg::mode_run;
                end
            end
            iepm_pkg::mode_pdown: begin
                if (r.sync_b[3]) begin
                    next_r.mode = iepm_pkg::mode_reset;  // interrupts ignored
                end
            end
            default: begin
                next_r.mode = iepm_pkg::mode_run;
            end
        endcase

        // internal reset reloads registers; ram is untouched
        if (r.mode == iepm_pkg::mode_reset) begin
            next_r.ie        = `IEPM_IE_RESET;
            next_r.t2_ovf    = 1'b0;
            next_r.t2_ext    = 1'b0;
            next_r.t2_ext_en = 1'b0;
            next_r.t2_updown = 1'b0;
            next_r.flag      = 4'h0;
            next_r.pend      = 3'h0;
            next_r.poll      = 6'h00;
            next_r.irq       = 6'h00;
        end

        // link outputs registered from the next mode
        next_r.halt     = (next_r.mode == iepm_pkg::mode_idle)
                       || (next_r.mode == iepm_pkg::mode_pdown);
        next_r.core_rst = (next_r.mode == iepm_pkg::mode_reset);
        next_r.ram_blk  = (next_r.mode == iepm_pkg::mode_window)
                       || (next_r.mode == iepm_pkg::mode_reset);
        next_r.osc_stop = (next_r.mode == iepm_pkg::mode_pdown);

        // apb setup: answer in the following access cycle
        if (psel && !penable) begin
            next_r.pready = 1'b1;
            next_r.prdata = 32'h0000_0000;
            if (paddr == `IEPM_OFF_ENABLE) begin
                next_r.prdata[7:0] = r.ie;
            end else if (paddr == `IEPM_OFF_T2CTL) begin
                next_r.prdata[`IEPM_T2_OVF]    = r.t2_ovf;
                next_r.prdata[`IEPM_T2_EXT]    = r.t2_ext;
                next_r.prdata[`IEPM_T2_EXT_EN] = r.t2_ext_en;
            end else if (paddr == `IEPM_OFF_T2MODE) begin
                next_r.prdata[`IEPM_T2_UPDOWN] = r.t2_updown;
            end else if (paddr == `IEPM_OFF_FLAGS) begin
                next_r.prdata[5:0] = req;
                next_r.prdata[`IEPM_IRQ_HI:`IEPM_IRQ_LO] = r.irq;
            end else if (paddr == `IEPM_OFF_POWER) begin
                next_r.prdata[2:0]           = r.mode;
                next_r.prdata[`IEPM_PWR_BLK] = r.ram_blk;
            end else begin
                next_r.pslverr = 1'b1;
            end
        end
    end

    // ============================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r        <= '0;
            r.sync_a <= 4'h7;  // pins idle high, reset pin low
            r.sync_b <= 4'h7;
            r.smp    <= 3'h7;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from the state register
    assign prdata               = r.prdata;
    assign pready               = r.pready;
    assign pslverr              = r.pslverr;
    assign link.irq_pending     = r.irq;
    assign link.core_halt       = r.halt;
    assign link.core_reset      = r.core_rst;
    assign link.ram_write_block = r.ram_blk;
    assign link.osc_stop        = r.osc_stop;
endmodule

// File: hdl/iepm_defines.svh
// constants for the interrupt enable and power mode controller
`ifndef IEPM_DEFINES_SVH
`define IEPM_DEFINES_SVH
// ==================== machine cycle timing ====================
`define IEPM_PHASES       4'hb
`define IEPM_PH_STATE2_PHASE2      4'h3
`define IEPM_PH_S4P1      4'h6
`define IEPM_PH_STATE5_PHASE2      4'h9
`define IEPM_RST_WIN_MC   2
`define IEPM_RST_WIN_CYC  5'h17
// ==================== register offsets ====================
`define IEPM_OFF_ENABLE   12'h000
`define IEPM_OFF_T2CTL    12'h004
`define IEPM_OFF_T2MODE   12'h008
`define IEPM_OFF_FLAGS    12'h00c
`define IEPM_OFF_POWER    12'h010
// ==================== field positions and reset values ====================
`define IEPM_IE_GLOBAL    7
`define IEPM_IE_IMPL      8'hbf
`define IEPM_IE_RESET     8'h00
`define IEPM_T2_OVF       7
`define IEPM_T2_EXT       6
`define IEPM_T2_EXT_EN    3
`define IEPM_T2_UPDOWN    0
`define IEPM_IRQ_HI       13
`define IEPM_IRQ_LO       8
`define IEPM_PWR_BLK      4
`endif

// File: hdl/iepm_link_if.sv
// link between the interrupt controller and the processor core
`timescale 1ns/1ps
interface iepm_link_if;
    logic [5:0] irq_pending;   // masked requests, bit order as enable register
    logic       core_halt;
    logic       core_reset;
    logic       ram_write_block;
    logic       osc_stop;
    logic       idle_req;
    logic       pdown_req;
    logic [5:0] vector_ack;

    modport dev (
        output irq_pending, core_halt, core_reset, ram_write_block, osc_stop,
        input  idle_req, pdown_req, vector_ack
    );
    modport core (
        input  irq_pending, core_halt, core_reset, ram_write_block, osc_stop,
        output idle_req, pdown_req, vector_ack
    );
endinterface

// File: hdl/iepm_pkg.sv
// types shared by both ends of the interrupt and power mode link
package iepm_pkg;
    // power mode states, gray coded along run, idle, window, reset
    typedef enum logic [2:0] {
        mode_run     = 3'h0,
        mode_idle    = 3'h1,
        mode_window  = 3'h3,
        mode_reset   = 3'h2,
        mode_pdown   = 3'h6
    } iepm_mode_t;

    typedef struct packed {
        iepm_mode_t  mode;
        logic [3:0]  phase;
        logic [4:0]  wcnt;
        logic [7:0]  ie;
        logic        t2_ovf;
        logic        t2_ext;
        logic        t2_ext_en;
        logic        t2_updown;
        logic [3:0]  flag;     // t1, ext1, t0, ext0 (bit 3 down to bit 0)
        logic [2:0]  pend;     // t2, t1, t0 overflow pulses awaiting their phase
        logic [3:0]  sync_a;
        logic [3:0]  sync_b;
        logic [2:0]  smp;
        logic [5:0]  poll;
        logic [5:0]  irq;
        logic        halt;
        logic        core_rst;
        logic        ram_blk;
        logic        osc_stop;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } iepm_dev_t;

    typedef struct packed {
        logic       idle_req;
        logic       pdown_req;
        logic [5:0] ack;
        logic       in_service;
        logic [2:0] vnum;
        logic       vvalid;
        logic       ram_we;
        logic       port_we;
        logic       active;
    } iepm_core_t;
endpackage

// File: verification/iepm_assertions.sv
// property checker on the link between the interrupt controller and the core
`timescale 1ns/1ps
`include "iepm_defines.svh"
module iepm_assertions (
    input logic       pclk,
    input logic       presetn,
    input logic [5:0] irq_pending,
    input logic       core_halt,
    input logic       core_reset,
    input logic       ram_write_block,
    input logic       osc_stop,
    input logic       idle_req,
    input logic       pdown_req,
    input logic [5:0] vector_ack
);
    // ==========================================
    // helper logic
    logic       in_win;
    logic [4:0] win_cnt;
    assign in_win = ram_write_block && !core_reset;
    // counts cycles spent in the pre-reset window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_cnt <= 5'h0;
        end else begin
            win_cnt <= in_win ? win_cnt + 5'h1 : 5'h0;
        end
    end
    // ==========================================
    // properties
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_run_free;
        !core_halt && !core_reset && !ram_write_block;
    endsequence
    sequence s_wake;
        core_halt && !osc_stop && (irq_pending != 6'h0);
    endsequence
    a_idle_entry: assert property (s_run_free ##0 idle_req |=> core_halt && !osc_stop)
        else $error("idle request did not halt the core");
    a_pdown_entry: assert property (s_run_free ##0 pdown_req |=> core_halt && osc_stop)
        else $error("power-down request did not stop the oscillator");
    a_pdown_halt: assert property (osc_stop |-> core_halt)
        else $error("core runs while oscillator stopped");
    a_pdown_exit: assert property ($fell(osc_stop) |-> ##[0:2] core_reset)
        else $error("power-down left without reset");
    a_idle_wake: assert property (s_wake |-> ##[1:2] !core_halt)
        else $error("pending interrupt did not end idle");
    a_ack_pending: assert property (vector_ack != 6'h0 |->
        $onehot(vector_ack) && ((vector_ack & $past(irq_pending)) == vector_ack))
        else $error("vector taken for a source not pending");
    a_ack_lowest: assert property (vector_ack != 6'h0 |->
        ($past(irq_pending) & (vector_ack - 6'h1)) == 6'h0)
        else $error("vector skipped a lower pending source");
    a_halt_no_ack: assert property (core_halt |-> vector_ack == 6'h0)
        else $error("vector taken while halted");
    a_reset_blocks: assert property (core_reset |-> ram_write_block)
        else $error("ram writes open during reset");
    a_window_clear: assert property (in_win |-> !core_halt && !osc_stop)
        else $error("core halted inside reset window");
    a_window_length: assert property (in_win |-> win_cnt <= `IEPM_RST_WIN_CYC)
        else $error("reset window too long");
    a_window_end: assert property (in_win && win_cnt == `IEPM_RST_WIN_CYC |=> core_reset)
        else $error("reset did not follow the window");
endmodule

// File: verification/irq_enable_power_modes_tb.sv
// self-checking bench joining the interrupt controller and the core end
`timescale 1ns/1ps
module irq_enable_power_modes_tb;
    // ==========================================
    // signals
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic        pin_a_n, pin_b_n, t2_pin, hw_rst, t0_ovf, t1_ovf, t2_ovf, ser;
    logic        idle_cmd, pdown_cmd, reti, ram_req, port_req, ram_en, port_en, vvalid, act;
    logic [2:0]  vnum;
    logic [32:0] rq[$];
    logic [32:0] vq[$];
    int          fails, num_checks;
    iepm_link_if link ();
    // ==========================================
    // both ends and the checker
    iepm_ctrl u_iepm_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_irq_pin_a_n(pin_a_n), .external_irq_pin_b_n(pin_b_n),
        .timer2_external_pin(t2_pin), .hw_reset_pin(hw_rst), .timer0_overflow(t0_ovf),
        .timer1_overflow(t1_ovf), .timer2_overflow(t2_ovf), .serial_irq_flag(ser), .link(link));
    iepm_core u_iepm_core (.pclk(pclk), .presetn(presetn), .link(link), .idle_cmd(idle_cmd),
        .pdown_cmd(pdown_cmd), .reti(reti), .ram_wr_req(ram_req), .port_wr_req(port_req),
        .ram_wr_en(ram_en), .port_wr_en(port_en), .vector_valid(vvalid), .vector_num(vnum),
        .core_active(act));
    iepm_assertions u_iepm_assertions (.pclk(pclk), .presetn(presetn),
        .irq_pending(link.irq_pending), .core_halt(link.core_halt), .core_reset(link.core_reset),
        .ram_write_block(link.ram_write_block), .osc_stop(link.osc_stop),
        .idle_req(link.idle_req), .pdown_req(link.pdown_req), .vector_ack(link.vector_ack));
    // ==========================================
    // tasks
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    // raises one interrupt source
    task automatic trig(input int i);
        @(posedge pclk);
        case (i)
            0: pin_a_n <= 1'b0;
            1: t0_ovf <= 1'b1;
            2: pin_b_n <= 1'b0;
            3: t1_ovf <= 1'b1;
            4: ser <= 1'b1;
            default: t2_ovf <= 1'b1;
        endcase
        @(posedge pclk);
        {t0_ovf, t1_ovf, t2_ovf} <= 3'h0;
        repeat (26) @(posedge pclk);
        {pin_a_n, pin_b_n} <= 2'h3;
    endtask
    // pulses idle (0), power-down (1) or return (2)
    task automatic cmd(input int k);
        @(posedge pclk);
        {idle_cmd, pdown_cmd, reti} <= 3'h4 >> k;
        @(posedge pclk);
        {idle_cmd, pdown_cmd, reti} <= 3'h0;
    endtask
    task automatic wait_vec();
        repeat (40) @(posedge pclk);
        chk(33'(vq.size()), 33'h0);
    endtask
    // ==========================================
    // clock, watchdog and result monitor
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (8000) @(posedge pclk);
        fails++;
        close_out();
    end
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            chk({pslverr, prdata}, rq.pop_front());
        end
        if (vvalid === 1'b1) begin
            chk(33'(vnum), (vq.size() > 0) ? vq.pop_front() : 33'h1_ffff_ffff);
        end
    end
    // ==========================================
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, t0_ovf, t1_ovf, t2_ovf, ser, hw_rst} = '0;
        {pin_a_n, pin_b_n, t2_pin, ram_req, port_req} = '1;
        {idle_cmd, pdown_cmd, reti, paddr, pwdata} = '0;
        fails = 0;
        num_checks = 0;
        r = $urandom(77);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h000, 33'h0);
        chk(33'(ram_en), 33'h1);
        r = $urandom();
        apb(1'b1, 12'h000, r & 32'hffff_ffbf); // bit six kept clear
        rd(12'h000, {25'h0, r[7:0] & 8'hbf});
        rd(12'h014, 33'h1_0000_0000);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, 12'h000, 32'h1 << i);
            trig(i);
            repeat (24) @(posedge pclk);
            rd(12'h00c, 33'h1 << i);
            vq.push_back(33'(i));
            apb(1'b1, 12'h000, 32'h80 | (32'h1 << i));
            wait_vec();
            if (i == 5) rd(12'h004, 33'h80);
            ser <= 1'b0;
            apb(1'b1, 12'h004, 32'h0);
            repeat (24) @(posedge pclk);
            cmd(2);
        end
        $display("test sources done");
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h004, 32'h8);
        t2_pin <= 1'b0;
        repeat (30) @(posedge pclk);
        t2_pin <= 1'b1;
        rd(12'h004, 33'h48);
        rd(12'h00c, 33'h20);
        apb(1'b1, 12'h008, 32'h1);
        apb(1'b1, 12'h004, 32'h40);
        rd(12'h00c, 33'h0);
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b1, 12'h004, 32'h0);
        $display("test timer2 done");
        apb(1'b1, 12'h000, 32'h82);
        port_req <= 1'b0; // no port write right after idle entry
        cmd(0);
        rd(12'h010, 33'h1);
        rd(12'h000, 33'h82);
        chk(33'(act), 33'h0);
        vq.push_back(33'h1);
        trig(1);
        wait_vec();
        cmd(2);
        rd(12'h010, 33'h0);
        $display("test idle done");
        port_req <= 1'b1;
        cmd(0);
        hw_rst <= 1'b1;
        repeat (4) @(posedge pclk);
        rd(12'h010, 33'h13);
        chk(33'(ram_en), 33'h0);
        chk(33'(port_en), 33'h1);
        chk(33'(act), 33'h1);
        repeat (30) @(posedge pclk);
        rd(12'h010, 33'h12);
        rd(12'h000, 33'h0);
        hw_rst <= 1'b0;
        repeat (6) @(posedge pclk);
        rd(12'h010, 33'h0);
        $display("test idle reset done");
        apb(1'b1, 12'h000, 32'h82);
        cmd(1);
        rd(12'h010, 33'h6);
        apb(1'b1, 12'h000, 32'h0);
        trig(1);
        repeat (40) @(posedge pclk);
        rd(12'h000, 33'h82);
        hw_rst <= 1'b1;
        repeat (10) @(posedge pclk); // held while the oscillator settles
        hw_rst <= 1'b0;
        repeat (6) @(posedge pclk);
        rd(12'h000, 33'h0);
        rd(12'h010, 33'h0);
        $display("test power-down done");
        close_out();
    end
endmodule
